// ### hdl/aecsr_pkg.sv
package aecsr_pkg;

  // core clock and conversion timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 2700;
  // a conversion lasts at least the printed time, so round up
  localparam int CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CONV_CNT_W = 9;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_LOAD =
    CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_RST = 9'h000;

  // result word
  localparam int RESULT_BITS = 16;
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 16'h0000;

  // serial frame: bit counter reaches this after the lsb is out
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_FIRST = 5'h01;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST  = 5'h10;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST   = 5'h00;

  // pin synchroniser lanes and their values during reset
  localparam int PIN_W        = 5;
  localparam int PIN_REQ_N    = 0;
  localparam int PIN_CS_N     = 1;
  localparam int PIN_SCLK     = 2;
  localparam int PIN_EXT_SEL  = 3;
  localparam int PIN_CASCADE  = 4;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h03;

  typedef enum logic [2:0]
  {
    FR_IDLE,
    FR_ARMED,
    FR_MARK,
    FR_SHIFT,
    FR_TAG
  } aecsr_frame_t;

endpackage

// ### hdl/aecsr_sync.sv
`timescale 1ns/100ps

module aecsr_sync
#(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
)
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output wire logic [W-1:0] pin_sync
);

  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } aecsr_sync_st_t;

  aecsr_sync_st_t st_r;
  aecsr_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt.meta   = pin_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r.meta   <= RST_VAL;
      st_r.stable <= RST_VAL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.stable;

endmodule

// ### hdl/aecsr_conv.sv
`timescale 1ns/100ps

module aecsr_conv
(
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              start,
  input  wire logic [aecsr_pkg::RESULT_BITS-1:0] sample_code,
  output wire logic                              busy_n,
  output wire logic                              done,
  output wire logic [aecsr_pkg::RESULT_BITS-1:0] result
);

  typedef struct packed
  {
    logic                              busy;
    logic                              done;
    logic [aecsr_pkg::CONV_CNT_W-1:0]  cnt;
    logic [aecsr_pkg::RESULT_BITS-1:0] held;
    logic [aecsr_pkg::RESULT_BITS-1:0] result;
  } aecsr_conv_st_t;

  aecsr_conv_st_t st_r;
  aecsr_conv_st_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (st_r.busy)
    begin
      // start requests during a conversion are dropped
      if (st_r.cnt == aecsr_pkg::CONV_CNT_RST)
      begin
        st_nxt.busy   = 1'b0;
        st_nxt.done   = 1'b1;
        st_nxt.result = st_r.held;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
    else if (start)
    begin
      // sample is held at the start edge
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = aecsr_pkg::CONV_CNT_LOAD;
      st_nxt.held = sample_code;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r.busy   <= 1'b0;
      st_r.done   <= 1'b0;
      st_r.cnt    <= aecsr_pkg::CONV_CNT_RST;
      st_r.held   <= aecsr_pkg::RESULT_RST;
      st_r.result <= aecsr_pkg::RESULT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign busy_n = ~st_r.busy;
  assign done   = st_r.done;
  assign result = st_r.result;

endmodule

// ### hdl/aecsr_top.sv
`timescale 1ns/100ps

module aecsr_top
(
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              conv_req_n,
  input  wire logic                              chip_sel_n,
  input  wire logic                              shift_clock,
  input  wire logic                              clock_source_select,
  input  wire logic                              cascade_in,
  input  wire logic [aecsr_pkg::RESULT_BITS-1:0] sample_code,
  output wire logic                              busy_n,
  output wire logic                              frame_mark,
  output wire logic                              serial_out
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed
  {
    logic                              prev_req_n;
    logic                              prev_cs_n;
    logic                              prev_sclk;
    logic                              gated;
    logic                              pend;
    aecsr_pkg::aecsr_frame_t           frame;
    logic [aecsr_pkg::BIT_CNT_W-1:0]   bit_cnt;
    logic [aecsr_pkg::RESULT_BITS-1:0] shreg;
    logic                              tag;
    logic                              mark;
    logic                              sdo;
  } aecsr_top_st_t;

  aecsr_top_st_t st_r;
  aecsr_top_st_t st_nxt;

  logic [aecsr_pkg::PIN_W-1:0]       pins;
  logic                              conv_busy_n;
  logic                              conv_done;
  logic [aecsr_pkg::RESULT_BITS-1:0] conv_result;

  logic req_n;
  logic cs_n;
  logic sclk;
  logic ext_mode;
  logic req_fall;
  logic req_rise;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic start_gated;
  logic start_free;
  logic start;
  logic arm_now;
  logic frame_busy;

  ////////////////////////////////////////////////////////////////////////////

  aecsr_sync
  #(
    .W       (aecsr_pkg::PIN_W),
    .RST_VAL (aecsr_pkg::PIN_RST)
  )
  u_sync
  (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({cascade_in, clock_source_select, shift_clock,
                chip_sel_n, conv_req_n}),
    .pin_sync (pins)
  );

  aecsr_conv u_conv
  (
    .clk         (clk),
    .reset       (reset),
    .start       (start),
    .sample_code (sample_code),
    .busy_n      (conv_busy_n),
    .done        (conv_done),
    .result      (conv_result)
  );

  ////////////////////////////////////////////////////////////////////////////

  assign req_n    = pins[aecsr_pkg::PIN_REQ_N];
  assign cs_n     = pins[aecsr_pkg::PIN_CS_N];
  assign sclk     = pins[aecsr_pkg::PIN_SCLK];
  assign ext_mode = pins[aecsr_pkg::PIN_EXT_SEL];

  assign req_fall  = st_r.prev_req_n & ~req_n;
  assign req_rise  = ~st_r.prev_req_n & req_n;
  assign cs_fall   = st_r.prev_cs_n & ~cs_n;
  assign cs_rise   = ~st_r.prev_cs_n & cs_n;
  // internal clock mode is not built, so the pin is ignored there
  assign sclk_rise = ext_mode & ~st_r.prev_sclk & sclk;

  assign start_gated = req_fall & ~cs_n;
  assign start_free  = cs_fall & ~req_n;
  assign start       = start_gated | start_free;

  // a gated completion never restarts a frame in flight; it waits in pend
  assign frame_busy = (st_r.frame == aecsr_pkg::FR_MARK) |
                      (st_r.frame == aecsr_pkg::FR_SHIFT);

  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.prev_req_n = req_n;
    st_nxt.prev_cs_n  = cs_n;
    st_nxt.prev_sclk  = sclk;
    arm_now           = 1'b0;

    if (start & conv_busy_n)
    begin
      st_nxt.gated = start_gated;
    end

    // gated start arms a read-during frame
    if (start_gated & conv_busy_n)
    begin
      arm_now = 1'b1;
    end
    // gated completion re-arms for a read-after frame
    if (conv_done & st_r.gated)
    begin
      if (frame_busy)
      begin
        st_nxt.pend = 1'b1;
      end
      else
      begin
        arm_now = 1'b1;
      end
    end
    if (cs_fall & req_n)
    begin
      arm_now = 1'b1;
    end
    if (req_rise & ~cs_n & ~st_r.gated)
    begin
      arm_now = 1'b1;
    end

    if (cs_rise)
    begin
      // deselect ends any frame and releases the marker
      st_nxt.frame = aecsr_pkg::FR_IDLE;
      st_nxt.mark  = 1'b0;
      st_nxt.pend  = 1'b0;
    end
    else if (arm_now)
    begin
      st_nxt.frame = aecsr_pkg::FR_ARMED;
    end
    else if (sclk_rise & ~cs_n)
    begin
      case (st_r.frame)
        aecsr_pkg::FR_ARMED:
        begin
          // latest finished result is copied at the marker edge
          st_nxt.mark  = 1'b1;
          st_nxt.shreg = conv_result;
          st_nxt.frame = aecsr_pkg::FR_MARK;
        end
        aecsr_pkg::FR_MARK:
        begin
          st_nxt.mark    = 1'b0;
          st_nxt.sdo     = st_r.shreg[aecsr_pkg::RESULT_BITS-1];
          st_nxt.shreg   = {st_r.shreg[aecsr_pkg::RESULT_BITS-2:0], 1'b0};
          st_nxt.tag     = pins[aecsr_pkg::PIN_CASCADE];
          st_nxt.bit_cnt = aecsr_pkg::BIT_CNT_FIRST;
          st_nxt.frame   = aecsr_pkg::FR_SHIFT;
        end
        aecsr_pkg::FR_SHIFT:
        begin
          if (st_r.bit_cnt == aecsr_pkg::BIT_CNT_LAST)
          begin
            // lsb held until this edge, then the cascade level
            st_nxt.sdo   = st_r.tag;
            st_nxt.frame = st_r.pend ? aecsr_pkg::FR_ARMED
                                     : aecsr_pkg::FR_TAG;
            st_nxt.pend  = 1'b0;
          end
          else
          begin
            st_nxt.sdo     = st_r.shreg[aecsr_pkg::RESULT_BITS-1];
            st_nxt.shreg   = {st_r.shreg[aecsr_pkg::RESULT_BITS-2:0], 1'b0};
            st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
          end
        end
        aecsr_pkg::FR_IDLE,
        aecsr_pkg::FR_TAG:
        begin
          st_nxt.frame = st_r.frame;
        end
        default:
        begin
          st_nxt.frame = aecsr_pkg::FR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r.prev_req_n <= aecsr_pkg::PIN_RST[aecsr_pkg::PIN_REQ_N];
      st_r.prev_cs_n  <= aecsr_pkg::PIN_RST[aecsr_pkg::PIN_CS_N];
      st_r.prev_sclk  <= aecsr_pkg::PIN_RST[aecsr_pkg::PIN_SCLK];
      st_r.gated      <= 1'b0;
      st_r.pend       <= 1'b0;
      st_r.frame      <= aecsr_pkg::FR_IDLE;
      st_r.bit_cnt    <= aecsr_pkg::BIT_CNT_RST;
      st_r.shreg      <= aecsr_pkg::RESULT_RST;
      st_r.tag        <= 1'b0;
      st_r.mark       <= 1'b0;
      st_r.sdo        <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign busy_n     = conv_busy_n;
  assign frame_mark = st_r.mark;
  assign serial_out = st_r.sdo;

endmodule

// ### sim/aecsr_chk.sv
`timescale 1ns/100ps

module aecsr_chk
(
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_req_n,
  input wire logic chip_sel_n,
  input wire logic shift_clock,
  input wire logic clock_source_select,
  input wire logic busy_n,
  input wire logic frame_mark,
  input wire logic serial_out
);
  logic [8:0] low_r;
  logic [8:0] low_nxt;
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  logic       sc_r;

  // age saturates so long idle spans never wrap into the window
  always_comb
  begin
    low_nxt = busy_n ? 9'h000 : low_r + 9'h001;
    age_nxt = (shift_clock && !sc_r) ? 4'h0
            : age_r + {3'h0, age_r != 4'hf};
  end

  always_ff @(posedge clk)
  begin
    low_r <= reset ? 9'h000 : low_nxt;
    age_r <= reset ? 4'hf : age_nxt;
    sc_r  <= shift_clock;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_mark_held;
    frame_mark[*8];
  endsequence

  a_busy_len: assert property ($rose(busy_n) |-> low_r == 9'h10e)
    else $error("busy low span wrong");
  a_busy_max: assert property (!busy_n |-> low_r < 9'h10e)
    else $error("busy held too long");
  a_gated_start: assert property ($fell(conv_req_n) && !chip_sel_n
    && busy_n |-> ##[1:5] !busy_n) else $error("gated start missed");
  a_free_start: assert property ($fell(chip_sel_n) && !conv_req_n
    && busy_n |-> ##[1:5] !busy_n) else $error("select start missed");
  a_mark_hold: assert property ($rose(frame_mark) |-> s_mark_held)
    else $error("marker too short");
  a_mark_drop: assert property ($rose(frame_mark) |->
    ##[9:16] !frame_mark) else $error("marker too long");
  a_mark_edge: assert property ($rose(frame_mark) |->
    age_r inside {[4'h1:4'h5]}) else $error("marker off edge");
  a_bit_edge: assert property ($changed(serial_out) |->
    age_r inside {[4'h1:4'h5]}) else $error("data off edge");
  a_src_off: assert property ((!clock_source_select)[*6] |->
    $stable(serial_out) && !$rose(frame_mark)) else $error("pin used");
  a_cs_quiet: assert property (chip_sel_n[*6] |->
    $stable(serial_out) && !frame_mark) else $error("shift unselected");
endmodule

bind aecsr_top aecsr_chk u_chk
(
  .clk(clk), .reset(reset), .conv_req_n(conv_req_n),
  .chip_sel_n(chip_sel_n), .shift_clock(shift_clock),
  .clock_source_select(clock_source_select), .busy_n(busy_n),
  .frame_mark(frame_mark), .serial_out(serial_out)
);

// ### sim/aecsr_host.sv
`timescale 1ns/100ps

module aecsr_host
(
  input  wire logic clk,
  input  wire logic busy_n,
  input  wire logic frame_mark,
  input  wire logic serial_out,
  output logic      conv_req_n,
  output logic      chip_sel_n,
  output logic      shift_clock,
  output logic      cascade_in
);
  logic [17:0] mk;
  logic [17:0] dt;

  initial
  begin
    conv_req_n  = 1'b1;
    chip_sel_n  = 1'b1;
    shift_clock = 1'b0;
    cascade_in  = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 400 && !busy_n; k++)
      @(posedge clk);
    ticks(4);
  endtask

  // 12/13 cycle periods average 125 ns; read while the clock is low
  task automatic frame(input logic tag);
    cascade_in <= tag;
    for (int i = 0; i < 18; i++)
    begin
      @(posedge clk);
      shift_clock <= 1'b1;
      ticks(6);
      shift_clock <= 1'b0;
      if (i == 1)
        cascade_in <= ~tag;
      @(negedge clk);
      mk[i] = frame_mark;
      dt[i] = serial_out;
      ticks(5 + i % 2);
    end
  endtask

  task automatic kick();
    conv_req_n <= 1'b0;
    ticks(20);
    conv_req_n <= 1'b1;
    ticks(4);
  endtask

  // mode bit 0: select starts it, bit 1: read while converting
  task automatic run(input logic [1:0] mode, input logic tag);
    if (mode[0])
      conv_req_n <= 1'b0;
    else
      chip_sel_n <= 1'b0;
    ticks(4);
    if (mode[0])
      chip_sel_n <= 1'b0;
    else
      conv_req_n <= 1'b0;
    ticks(20);
    if (mode == 2'h1)
      chip_sel_n <= 1'b1;
    ticks(4);
    conv_req_n <= 1'b1;
    ticks(4);
    if (!mode[1])
      wait_idle();
    chip_sel_n <= 1'b0;
    ticks(4);
    frame(tag);
    chip_sel_n <= 1'b1;
    wait_idle();
  endtask
endmodule

// ### sim/aecsr_tb_top.sv
`timescale 1ns/100ps

module aecsr_tb_top;
  typedef struct packed
  {
    logic [1:0]  mode;
    logic [15:0] code;
    logic        tag;
  } aecsr_row_t;

  localparam aecsr_row_t ROWS [8] = '{
    '{2'h0, 16'h8001, 1'b1}, '{2'h1, 16'h7ffe, 1'b0},
    '{2'h2, 16'hffff, 1'b1}, '{2'h3, 16'h0000, 1'b0},
    '{2'h3, 16'h5a3c, 1'b1}, '{2'h2, 16'h0f0f, 1'b0},
    '{2'h1, 16'hf0f0, 1'b1}, '{2'h0, 16'h0001, 1'b0}};

  logic        clk;
  logic        reset;
  logic        clock_source_select;
  logic [15:0] sample_code;
  logic [15:0] prev;
  wire logic   conv_req_n;
  wire logic   chip_sel_n;
  wire logic   shift_clock;
  wire logic   cascade_in;
  wire logic   busy_n;
  wire logic   frame_mark;
  wire logic   serial_out;
  int          n_fail = 0;
  int          checks = 0;

  aecsr_top DUT
  (
    .clk(clk), .reset(reset), .conv_req_n(conv_req_n),
    .chip_sel_n(chip_sel_n), .shift_clock(shift_clock),
    .clock_source_select(clock_source_select), .cascade_in(cascade_in),
    .sample_code(sample_code), .busy_n(busy_n),
    .frame_mark(frame_mark), .serial_out(serial_out)
  );

  aecsr_host host
  (
    .clk(clk), .busy_n(busy_n), .frame_mark(frame_mark),
    .serial_out(serial_out), .conv_req_n(conv_req_n),
    .chip_sel_n(chip_sel_n), .shift_clock(shift_clock),
    .cascade_in(cascade_in)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic expect_frame(input logic [15:0] code, input logic tag);
    logic [15:0] rev;
    rev = {<<{code}};
    check(host.mk, 18'h00001);
    check({host.dt[17:1], 1'b0}, {tag, rev, 1'b0});
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // rows need about 3200 cycles; the margin covers the hand tests
  initial
  begin
    #300us;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    reset = 1'b1;
    clock_source_select = 1'b1;
    sample_code = 16'h0000;
    prev = 16'h0000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      sample_code <= ROWS[i].code;
      host.run(ROWS[i].mode, ROWS[i].tag);
      expect_frame(ROWS[i].mode[1] ? prev : ROWS[i].code, ROWS[i].tag);
      prev = ROWS[i].code;
    end
    clock_source_select <= 1'b0;
    sample_code <= 16'hc3a5;
    host.run(2'h0, 1'b1);
    check(host.mk, 18'h00000);
    check(host.dt & 18'h3fffe, 18'h00000);
    clock_source_select <= 1'b1;
    host.chip_sel_n <= 1'b0;
    host.ticks(4);
    host.frame(1'b1);
    expect_frame(16'hc3a5, 1'b1);
    sample_code <= 16'h1234;
    host.chip_sel_n <= 1'b0;
    fork
      begin
        host.kick();
        host.ticks(100);
        host.kick();
        host.wait_idle();
      end
      begin
        repeat (60) @(posedge clk);
        sample_code <= 16'hedcb;
      end
    join
    host.frame(1'b0);
    expect_frame(16'h1234, 1'b0);
    reset <= 1'b1;
    repeat (7) @(posedge clk);
    @(negedge clk);
    check({15'h0000, busy_n, frame_mark, serial_out}, 18'h00004);
    @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    report_and_stop();
  end
endmodule
